// file: rtl/can_id_acceptance_mask_filter.sv
// CAN receive acceptance stage with host-loaded mask and filter
`timescale 1ns/100ps
module can_id_acceptance_mask_filter (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Host command port
    input wire logic cmd_valid,
    input wire can_accept_pkg::cmd_t cmd_code,
    input wire logic cmd_has_arg,
    input wire logic cmd_ext,
    input wire logic [can_accept_pkg::ID_W-1:0] cmd_value,
    input wire logic [can_accept_pkg::NIB_N-1:0] cmd_wild,
    output logic cmd_ok,
    // Traffic class setting
    input wire can_accept_pkg::class_t traffic_class,
    // Received frames
    input wire logic frame_valid,
    input wire logic frame_ext,
    input wire logic [can_accept_pkg::ID_W-1:0] frame_id,
    // Acceptance result
    output logic frame_accept,
    output logic frame_reject,
    output logic [can_accept_pkg::ID_W-1:0] frame_id_out,
    output logic frame_ext_out,
    // Status
    output logic user_filter_active
);

    typedef struct packed {
        logic [can_accept_pkg::ID_W-1:0] mask;
        logic [can_accept_pkg::ID_W-1:0] filt;
        logic pat_set;
        logic mask_set;
        logic user;
        logic ok;
        logic acc;
        logic rej;
        logic [can_accept_pkg::ID_W-1:0] id_d;
        logic ext_d;
        logic [can_accept_pkg::ID_W-1:0] id_out;
        logic ext_out;
    } top_state_t;

    top_state_t st_r;
    top_state_t st_nxt;
    logic user_on;
    logic [can_accept_pkg::ID_W-1:0] sel_mask;
    logic [can_accept_pkg::ID_W-1:0] sel_filt;
    logic [can_accept_pkg::ID_W-1:0] cmd_span;

    accept_if acc_link ();

    accept_compare u_compare (
        .clock(clock),
        .reset_n(reset_n),
        .cmp(acc_link.comparator)
    );

    // ***************************************************
    // Pattern selection
    // ***************************************************
    // Registered so the status pin comes straight from a flip-flop
    assign user_on = st_r.user;

    always_comb begin
        if (user_on) begin
            sel_mask = st_r.mask;
            sel_filt = st_r.filt;
        end else if (traffic_class == can_accept_pkg::CLASS_HEAVY) begin
            sel_mask = can_accept_pkg::HEAVY_MASK;
            sel_filt = can_accept_pkg::HEAVY_FILTER;
        end else if (frame_ext) begin
            sel_mask = can_accept_pkg::DIAG_EXT_MASK;
            sel_filt = can_accept_pkg::DIAG_EXT_FILTER;
        end else begin
            sel_mask = can_accept_pkg::DIAG_STD_MASK;
            sel_filt = can_accept_pkg::DIAG_STD_FILTER;
        end
    end

    // Standard values keep eleven bits, dropping the upper bit of their top digit
    assign cmd_span = cmd_ext ? {can_accept_pkg::ID_W{1'b1}} : can_accept_pkg::STD_KEEP;

    assign acc_link.valid = frame_valid;
    assign acc_link.ext = frame_ext;
    assign acc_link.id = frame_ext ? frame_id : (frame_id & can_accept_pkg::STD_KEEP);
    assign acc_link.mask = sel_mask;
    assign acc_link.filt = sel_filt;

    // ***************************************************
    // Command handling and result registers
    // ***************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.ok = 1'b0;
        if (cmd_valid) begin
            case (cmd_code)
                can_accept_pkg::ACCEPTANCE_PATTERN_LOAD_CMD: begin
                    st_nxt.filt = cmd_value & cmd_span;
                    st_nxt.pat_set = 1'b1;
                    st_nxt.ok = 1'b1;
                end
                can_accept_pkg::ACCEPTANCE_MASK_LOAD_CMD: begin
                    st_nxt.mask = cmd_value & cmd_span;
                    st_nxt.mask_set = 1'b1;
                    st_nxt.ok = 1'b1;
                end
                can_accept_pkg::RECEIVE_ID_SELECT_CMD: begin
                    if (cmd_has_arg) begin
                        st_nxt.mask = can_accept_pkg::wild_to_mask(cmd_wild) & cmd_span;
                        st_nxt.filt = cmd_value & can_accept_pkg::wild_to_mask(cmd_wild)
                                      & cmd_span;
                        st_nxt.pat_set = 1'b1;
                        st_nxt.mask_set = 1'b1;
                    end else begin
                        st_nxt.mask = can_accept_pkg::RESET_MASK;
                        st_nxt.filt = can_accept_pkg::RESET_FILTER;
                        st_nxt.pat_set = 1'b0;
                        st_nxt.mask_set = 1'b0;
                    end
                    st_nxt.ok = 1'b1;
                end
                can_accept_pkg::DEFAULTS_RESTORE_CMD,
                can_accept_pkg::WARM_RESTART_CMD: begin
                    st_nxt.mask = can_accept_pkg::RESET_MASK;
                    st_nxt.filt = can_accept_pkg::RESET_FILTER;
                    st_nxt.pat_set = 1'b0;
                    st_nxt.mask_set = 1'b0;
                    st_nxt.ok = 1'b1;
                end
                default: begin
                    st_nxt.ok = 1'b0;
                end
            endcase
        end
        if (frame_valid) begin
            st_nxt.id_d = acc_link.id;
            st_nxt.ext_d = frame_ext;
        end
        st_nxt.acc = acc_link.done && acc_link.accept;
        st_nxt.rej = acc_link.done && !acc_link.accept;
        if (acc_link.done) begin
            st_nxt.id_out = st_r.id_d;
            st_nxt.ext_out = st_r.ext_d;
        end
        st_nxt.user = st_nxt.pat_set && st_nxt.mask_set;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cmd_ok = st_r.ok;
    assign frame_accept = st_r.acc;
    assign frame_reject = st_r.rej;
    assign frame_id_out = st_r.id_out;
    assign frame_ext_out = st_r.ext_out;
    assign user_filter_active = user_on;

    // ***************************************************
    // Checks
    // ***************************************************
    sequence frame_in_s;
        frame_valid;
    endsequence

    sequence verdict_s;
        ##2 (frame_accept ^ frame_reject);
    endsequence

    AST_ONE_VERDICT_PER_FRAME: assert property (@(posedge clock) disable iff (!reset_n)
        frame_in_s |-> verdict_s)
        else $error("Frame did not get exactly one verdict two cycles later");

    AST_NO_SPURIOUS_VERDICT: assert property (@(posedge clock) disable iff (!reset_n)
        (frame_accept || frame_reject) |-> $past(frame_valid, 2))
        else $error("Verdict without a frame");

    AST_VERDICT_FOLLOWS_MATCH: assert property (@(posedge clock) disable iff (!reset_n)
        (frame_valid && user_on && !cmd_valid)
        |-> ##2 (frame_accept == can_accept_pkg::id_match(
                    $past(st_r.mask, 2), $past(st_r.filt, 2), $past(acc_link.id, 2),
                    $past(frame_ext, 2))))
        else $error("User filter verdict differs from mask and filter match");

    AST_CMD_ANSWERED_OK: assert property (@(posedge clock) disable iff (!reset_n)
        (cmd_valid && cmd_code != can_accept_pkg::CMD_NONE &&
         cmd_code <= can_accept_pkg::WARM_RESTART_CMD) |=> cmd_ok)
        else $error("Command not answered with OK");

    AST_OK_ONE_CYCLE: assert property (@(posedge clock) disable iff (!reset_n)
        cmd_ok |-> $past(cmd_valid))
        else $error("OK without a command");

    AST_RESTORE_DEFAULTS: assert property (@(posedge clock) disable iff (!reset_n)
        (cmd_valid && (cmd_code == can_accept_pkg::DEFAULTS_RESTORE_CMD ||
                       cmd_code == can_accept_pkg::WARM_RESTART_CMD ||
                       (cmd_code == can_accept_pkg::RECEIVE_ID_SELECT_CMD && !cmd_has_arg)))
        |=> !user_filter_active)
        else $error("Defaults not restored");

    AST_STD_TOP_DIGIT: assert property (@(posedge clock) disable iff (!reset_n)
        (cmd_valid && !cmd_ext && cmd_code == can_accept_pkg::ACCEPTANCE_MASK_LOAD_CMD)
        |=> (st_r.mask[can_accept_pkg::ID_W-1:can_accept_pkg::STD_W] == '0))
        else $error("Standard mask kept bits above eleven");

    AST_WILDCARD_NIBBLE: assert property (@(posedge clock) disable iff (!reset_n)
        (cmd_valid && cmd_ext && cmd_has_arg && cmd_wild[0] &&
         cmd_code == can_accept_pkg::RECEIVE_ID_SELECT_CMD)
        |=> (st_r.mask[3:0] == 4'h0) && user_filter_active)
        else $error("Wildcard nibble still cared for");

    AST_DEFAULT_CLASS: assert property (@(posedge clock) disable iff (!reset_n)
        (frame_valid && !user_on && !cmd_valid && traffic_class == can_accept_pkg::CLASS_HEAVY)
        |-> ##2 frame_accept)
        else $error("Heavy-vehicle default did not pass every frame");

endmodule : can_id_acceptance_mask_filter

// file: rtl/can_accept_pkg.sv
// Shared constants, types and functions of the CAN acceptance stage
package can_accept_pkg;

    // ***************************************************
    // Widths
    // ***************************************************
    localparam int ID_W = 29;
    localparam int STD_W = 11;
    localparam int NIB_N = 8;

    // ***************************************************
    // Reset values and per-class default patterns
    // ***************************************************
    localparam logic [ID_W-1:0] RESET_MASK = 29'h00000000;
    localparam logic [ID_W-1:0] RESET_FILTER = 29'h00000000;
    localparam logic [ID_W-1:0] DIAG_STD_FILTER = 29'h000007E8;
    localparam logic [ID_W-1:0] DIAG_STD_MASK = 29'h000007F8;
    localparam logic [ID_W-1:0] DIAG_EXT_FILTER = 29'h18DAF100;
    localparam logic [ID_W-1:0] DIAG_EXT_MASK = 29'h1FFFFF00;
    localparam logic [ID_W-1:0] HEAVY_FILTER = 29'h00000000;
    localparam logic [ID_W-1:0] HEAVY_MASK = 29'h00000000;
    localparam logic [ID_W-1:0] STD_KEEP = 29'h000007FF;

    // ***************************************************
    // Host commands and traffic classes
    // ***************************************************
    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        ACCEPTANCE_PATTERN_LOAD_CMD = 3'h1,
        ACCEPTANCE_MASK_LOAD_CMD = 3'h2,
        RECEIVE_ID_SELECT_CMD = 3'h3,
        DEFAULTS_RESTORE_CMD = 3'h4,
        WARM_RESTART_CMD = 3'h5
    } cmd_t;

    typedef enum logic {
        CLASS_DIAG = 1'b0,
        CLASS_HEAVY = 1'b1
    } class_t;

    // ***************************************************
    // Functions
    // ***************************************************
    // Accept when no cared-for bit differs
    function automatic logic id_match(input logic [ID_W-1:0] mask,
                                      input logic [ID_W-1:0] filt,
                                      input logic [ID_W-1:0] id,
                                      input logic ext);
        logic [ID_W-1:0] span;
        span = ext ? {ID_W{1'b1}} : STD_KEEP;
        return ((mask & span & (id ^ filt)) == '0);
    endfunction : id_match

    // Zero mask nibbles where the digit is a wildcard
    function automatic logic [ID_W-1:0] wild_to_mask(input logic [NIB_N-1:0] wild);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < NIB_N; i++) begin
            m[i*4 +: 4] = wild[i] ? 4'h0 : 4'hF;
        end
        return m[ID_W-1:0];
    endfunction : wild_to_mask

endpackage : can_accept_pkg

// file: rtl/accept_if.sv
// Link between the acceptance controller and its comparator
`timescale 1ns/100ps
interface accept_if;
    logic valid;
    logic ext;
    logic [can_accept_pkg::ID_W-1:0] id;
    logic [can_accept_pkg::ID_W-1:0] mask;
    logic [can_accept_pkg::ID_W-1:0] filt;
    logic done;
    logic accept;

    modport requester (output valid, ext, id, mask, filt, input done, accept);
    modport comparator (input valid, ext, id, mask, filt, output done, accept);
endinterface : accept_if

// file: rtl/accept_compare.sv
// Registered mask and filter comparison of one frame identifier
`timescale 1ns/100ps
module accept_compare (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Request and result
    accept_if.comparator cmp
);

    typedef struct packed {
        logic done;
        logic accept;
    } cmp_state_t;

    cmp_state_t st_r;
    cmp_state_t st_nxt;

    // ***************************************************
    // Comparison
    // ***************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = cmp.valid;
        st_nxt.accept = cmp.valid &&
            can_accept_pkg::id_match(cmp.mask, cmp.filt, cmp.id, cmp.ext);
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cmp.done = st_r.done;
    assign cmp.accept = st_r.accept;

    // ***************************************************
    // Checks
    // ***************************************************
    AST_CARED_MISMATCH_REJECTS: assert property (@(posedge clock) disable iff (!reset_n)
        (cmp.valid && ((cmp.mask & (cmp.id ^ cmp.filt) & can_accept_pkg::STD_KEEP) != '0))
        |=> !cmp.accept)
        else $error("Mismatch on a cared-for bit was accepted");

    AST_DONT_CARE_IGNORED: assert property (@(posedge clock) disable iff (!reset_n)
        (cmp.valid && cmp.ext && ((cmp.mask & (cmp.id ^ cmp.filt)) == '0))
        |=> cmp.accept)
        else $error("Difference under a zero mask bit caused rejection");

    AST_STD_HIGH_BITS_IGNORED: assert property (@(posedge clock) disable iff (!reset_n)
        (cmp.valid && !cmp.ext &&
         ((cmp.mask & (cmp.id ^ cmp.filt) & can_accept_pkg::STD_KEEP) == '0))
        |=> cmp.accept)
        else $error("Standard frame judged on bits above its identifier");

endmodule : accept_compare

// file: verification/ecu_frame_source.sv
// Model of the bus-side ECUs handing received frame identifiers to the stage
`timescale 1ns/100ps
module ecu_frame_source (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Bench request
    input wire logic send,
    input wire logic send_ext,
    input wire logic [can_accept_pkg::ID_W-1:0] send_id,
    // Frame towards the stage
    output logic frame_valid,
    output logic frame_ext,
    output logic [can_accept_pkg::ID_W-1:0] frame_id
);
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            frame_valid <= 1'h0;
            frame_ext <= 1'h0;
            frame_id <= '0;
        end else if (send) begin
            frame_valid <= 1'h1;
            frame_ext <= send_ext;
            frame_id <= send_id;
        end else begin
            // Between frames the lines never keep the last identifier
            frame_valid <= 1'h0;
            frame_ext <= ~frame_ext;
            frame_id <= ~frame_id;
        end
    end
endmodule : ecu_frame_source

// file: verification/can_id_acceptance_mask_filter_test.sv
// Self-checking bench of the CAN acceptance stage
`timescale 1ns/100ps
module can_id_acceptance_mask_filter_test;
    localparam can_accept_pkg::cmd_t NON = can_accept_pkg::CMD_NONE;
    localparam can_accept_pkg::cmd_t PAT = can_accept_pkg::ACCEPTANCE_PATTERN_LOAD_CMD;
    localparam can_accept_pkg::cmd_t MSK = can_accept_pkg::ACCEPTANCE_MASK_LOAD_CMD;
    localparam can_accept_pkg::cmd_t SEL = can_accept_pkg::RECEIVE_ID_SELECT_CMD;
    localparam can_accept_pkg::cmd_t DEF = can_accept_pkg::DEFAULTS_RESTORE_CMD;
    localparam can_accept_pkg::cmd_t WRM = can_accept_pkg::WARM_RESTART_CMD;
    typedef struct {
        can_accept_pkg::cmd_t code;
        logic arg;
        logic ext;
        logic [28:0] val;
        logic [7:0] wild;
        logic fext;
        logic [28:0] fid;
        logic acc;
    } row_t;
    logic clock, reset_n, cmd_valid, cmd_has_arg, cmd_ext, cmd_ok, frame_valid, frame_ext;
    logic frame_accept, frame_reject, frame_ext_out, user_filter_active, send, send_ext;
    can_accept_pkg::cmd_t cmd_code;
    can_accept_pkg::class_t traffic_class;
    logic [28:0] cmd_value, frame_id, frame_id_out, send_id;
    logic [7:0] cmd_wild;
    int miscompares = 0;
    int comparisons = 0;
    can_accept_pkg::cmd_t rst [3] = '{SEL, DEF, WRM};
    row_t rows [18] = '{
        '{NON, 1'h0, 1'h0, 29'h0, 8'h0, 1'h0, 29'h7E9, 1'h1},
        '{NON, 1'h0, 1'h0, 29'h0, 8'h0, 1'h0, 29'h7E0, 1'h0},
        '{NON, 1'h0, 1'h0, 29'h0, 8'h0, 1'h1, 29'h18DAF110, 1'h1},
        '{NON, 1'h0, 1'h0, 29'h0, 8'h0, 1'h1, 29'h18DAF210, 1'h0},
        '{PAT, 1'h0, 1'h0, 29'hFE8, 8'h0, 1'h0, 29'h7EF, 1'h1},
        '{MSK, 1'h0, 1'h0, 29'hFF8, 8'h0, 1'h0, 29'h7EF, 1'h1},
        '{NON, 1'h0, 1'h0, 29'h0, 8'h0, 1'h0, 29'h7F7, 1'h0},
        '{NON, 1'h0, 1'h0, 29'h0, 8'h0, 1'h0, 29'h1FFFF7E9, 1'h1},
        '{NON, 1'h0, 1'h0, 29'h0, 8'h0, 1'h1, 29'h7E9, 1'h1},
        '{NON, 1'h0, 1'h0, 29'h0, 8'h0, 1'h1, 29'h6E9, 1'h0},
        '{PAT, 1'h0, 1'h1, 29'h18DAF100, 8'h0, 1'h1, 29'h18DAF1A5, 1'h0},
        '{MSK, 1'h0, 1'h1, 29'h1FFFFF00, 8'h0, 1'h1, 29'h18DAF1A5, 1'h1},
        '{NON, 1'h0, 1'h0, 29'h0, 8'h0, 1'h1, 29'h18DAF0A5, 1'h0},
        '{MSK, 1'h0, 1'h1, 29'h0, 8'h0, 1'h1, 29'hABCDEF1, 1'h1},
        '{SEL, 1'h1, 1'h0, 29'h7E0, 8'h01, 1'h0, 29'h7EC, 1'h1},
        '{NON, 1'h0, 1'h0, 29'h0, 8'h0, 1'h0, 29'h7DC, 1'h0},
        '{SEL, 1'h1, 1'h1, 29'h18DAF110, 8'h03, 1'h1, 29'h18DAF1FF, 1'h1},
        '{NON, 1'h0, 1'h0, 29'h0, 8'h0, 1'h1, 29'h18DAF0FF, 1'h0}};

    // ***************************************************
    // Design, frame source and clock
    // ***************************************************
    can_id_acceptance_mask_filter u_dut (.clock(clock), .reset_n(reset_n),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_has_arg(cmd_has_arg),
        .cmd_ext(cmd_ext), .cmd_value(cmd_value), .cmd_wild(cmd_wild), .cmd_ok(cmd_ok),
        .traffic_class(traffic_class), .frame_valid(frame_valid), .frame_ext(frame_ext),
        .frame_id(frame_id), .frame_accept(frame_accept), .frame_reject(frame_reject),
        .frame_id_out(frame_id_out), .frame_ext_out(frame_ext_out),
        .user_filter_active(user_filter_active));
    ecu_frame_source u_ecu (.clock(clock), .reset_n(reset_n), .send(send),
        .send_ext(send_ext), .send_id(send_id), .frame_valid(frame_valid),
        .frame_ext(frame_ext), .frame_id(frame_id));
    initial begin
        clock = 1'h0;
        forever #2.5 clock = ~clock;
    end

    // ***************************************************
    // Tasks
    // ***************************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wrap_up;
        $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    task automatic cmd(input can_accept_pkg::cmd_t code, input logic arg, input logic ext,
                       input logic [28:0] val, input logic [7:0] wild, input logic ok);
        @(posedge clock);
        cmd_valid <= 1'h1;
        cmd_code <= code;
        cmd_has_arg <= arg;
        cmd_ext <= ext;
        cmd_value <= val;
        cmd_wild <= wild;
        @(posedge clock);
        cmd_valid <= 1'h0;
        #1;
        check("cmd ok", ok, cmd_ok);
    endtask : cmd

    task automatic frame(input logic ext, input logic [28:0] id, input logic acc);
        int n;
        @(posedge clock);
        send <= 1'h1;
        send_ext <= ext;
        send_id <= id;
        @(posedge clock);
        send <= 1'h0;
        n = 1;
        #1;
        while (n < 8 && frame_accept !== 1'h1 && frame_reject !== 1'h1) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n == 8) begin
            miscompares++;
            wrap_up();
        end
        check("latency", 3, n);
        check("accept", acc, frame_accept);
        check("reject", !acc, frame_reject);
        check("id out", ext ? id : id & 29'h7FF, frame_id_out);
        check("ext out", ext, frame_ext_out);
    endtask : frame

    // ***************************************************
    // Main sequence
    // ***************************************************
    initial begin
        {reset_n, cmd_valid, cmd_has_arg, cmd_ext, send, send_ext} = '0;
        {cmd_value, send_id, cmd_wild} = '0;
        cmd_code = NON;
        traffic_class = can_accept_pkg::CLASS_DIAG;
        repeat (16) @(posedge clock);
        reset_n <= 1'h1;
        foreach (rows[i]) begin
            if (rows[i].code != NON) begin
                cmd(rows[i].code, rows[i].arg, rows[i].ext, rows[i].val, rows[i].wild, 1'h1);
            end
            frame(rows[i].fext, rows[i].fid, rows[i].acc);
        end
        foreach (rst[i]) begin
            cmd(SEL, 1'h1, 1'h1, 29'h18DAF110, 8'h03, 1'h1);
            frame(1'h0, 29'h7E9, 1'h0);
            cmd(rst[i], 1'h0, 1'h0, 29'h0, 8'h0, 1'h1);
            check("user active", 0, user_filter_active);
            frame(1'h0, 29'h7E9, 1'h1);
        end
        cmd(PAT, 1'h0, 1'h0, 29'h7E8, 8'h0, 1'h1);
        check("user active", 0, user_filter_active);
        cmd(MSK, 1'h0, 1'h0, 29'h7F8, 8'h0, 1'h1);
        check("user active", 1, user_filter_active);
        @(posedge clock);
        send <= 1'h1;
        send_id <= 29'h7E9;
        @(posedge clock);
        send_id <= 29'h7E0;
        @(posedge clock);
        send <= 1'h0;
        @(posedge clock);
        #1;
        check("first accept", 1, frame_accept);
        @(posedge clock);
        #1;
        check("second reject", 1, frame_reject);
        cmd(DEF, 1'h0, 1'h0, 29'h0, 8'h0, 1'h1);
        @(posedge clock);
        traffic_class <= can_accept_pkg::CLASS_HEAVY;
        frame(1'h0, 29'h123, 1'h1);
        @(posedge clock);
        traffic_class <= can_accept_pkg::CLASS_DIAG;
        frame(1'h0, 29'h123, 1'h0);
        // Refused codes 0, 6 and 7 must stay unanswered
        for (int c = 5; c < 8; c++) begin
            cmd(can_accept_pkg::cmd_t'(c == 5 ? 3'h0 : c[2:0]), 1'h0, 1'h0, 29'h0, 8'h0,
                1'h0);
        end
        cmd(SEL, 1'h1, 1'h0, 29'h7E0, 8'h01, 1'h1);
        @(posedge clock);
        reset_n <= 1'h0;
        repeat (2) @(posedge clock);
        check("reset outputs", 0, {cmd_ok, frame_accept, frame_reject, user_filter_active});
        reset_n <= 1'h1;
        frame(1'h0, 29'h7E9, 1'h1);
        wrap_up();
    end
endmodule : can_id_acceptance_mask_filter_test
